// ==== logic/upm_defs.vh ====
// constants for the uart power and line mode block
// assumes a single 200 MHz core clock and an 8-bit register port
`ifndef UPM_DEFS_VH
`define UPM_DEFS_VH
// register offsets on the 4-bit register port
`define UPM_OFS_THR 4'h0
`define UPM_OFS_IER 4'h1
`define UPM_OFS_ISR 4'h2
`define UPM_OFS_MCR 4'h4
`define UPM_OFS_MSR 4'h6
`define UPM_OFS_FEATURE_CONTROL_REG 4'h8
`define UPM_OFS_DIV 4'h9
`define UPM_OFS_EVT 4'ha
`define UPM_OFS_MASK 4'hb
`define UPM_OFS_STAT 4'hc
// field positions
`define UPM_IER_SLEEP 4
`define UPM_MCR_LOOP 4
`define UPM_MCR_IR 6
`define UPM_FEATURE_CONTROL_REG_INV 2
// event bits of the sticky status register
`define UPM_EV_PUMPOFF 0
`define UPM_EV_PUMPON 1
`define UPM_EV_WAKE 2
`define UPM_EV_PSAVE 3
// reset values and codes
`define UPM_RST_BYTE 8'h00
`define UPM_RST_DIV 8'h00
`define UPM_ISR_NONE 8'h01
`define UPM_ZERO4 4'h0
// timing: clock rate and documented times
`define UPM_CLK_HZ 200000000
`define UPM_IDLE_S 30
`define UPM_RECOV_NS 45000
`define UPM_CLK_NS 5
// oscillator restart model, in cycles
`define UPM_OSC_CYC 12'h100
// infrared pulse: 3 of 16 sub-bit ticks
`define UPM_IR_ON_TICKS 4'h3
`define UPM_IR_LAST_TICK 4'hf
`endif

// ==== logic/upm_power_line.v ====
// power, sleep, power-save and line-mode control of a two-channel uart
// assumes the uart core supplies tx activity, interrupt state and serial
// bit streams, and that every input is synchronous to core_clk
//
// Overview of operation
// RQ1 - awake, select high: idle 30 s, pump off
// RQ2 - pump off: drivers off, receivers and registers live
// RQ3 - rx edge, tx load, modem rise restart pump
// RQ4 - host waits 45 us before sending
// RQ5 - asleep, select high: pump off at once
// RQ6 - power-save when pin high and asleep
// RQ7 - power-save wakes on rx or modem only
// RQ8 - back to power-save once serviced and cleared
// RQ9 - repeats until sleep bit or pin cleared
// RQ10 - wake interrupt after oscillator ready, read clears
// RQ11 - wake shows only with no other interrupt
// RQ12 - rx characters may drop during oscillator restart
// RQ13 - infrared sends 3/16 high pulse per zero
// RQ14 - modem control bit 6 enables infrared, idle low
// RQ15 - light pulse gives high; feature bit inverts input
// RQ16 - infrared only on channel b
// RQ17 - modem control bit 4 loops tx into rx
// RQ18 - sleep needs no irq, divisor, enable, quiet lines
// RQ19 - idle timer restarts on activity, off when deselected
//
// The placing of the registers and the plain strobed port were left to the implementer.
`include "upm_defs.vh"
module upm_power_line #(
  parameter [63:0] PUMP_IDLE_CYC = 64'd`UPM_IDLE_S * 64'd`UPM_CLK_HZ,
  parameter [15:0] PUMP_RECOV_CYC =
    16'd`UPM_RECOV_NS / 16'd`UPM_CLK_NS
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register port
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // straps
  input wire autoPumpShutdownSelect,
  input wire busIsolationPin,
  // modem and general purpose inputs
  input wire [3:0] modemIn,
  // uart core side
  input wire txActive,
  input wire coreIntPending,
  input wire [3:0] coreIntCode,
  input wire txSerialA,
  input wire txSerialB,
  input wire txBitStartB,
  input wire [1:0] drvRequest,
  output wire rxToCoreA,
  output wire rxToCoreB,
  output reg txLoad,
  output reg [7:0] txLoadData,
  // line side
  input wire rxLineA,
  input wire chanBSerialIn,
  output wire chanBSerialOut,
  output wire [1:0] rs485DrvEn,
  // power state
  output reg pumpOn,
  output wire sleeping,
  output wire powerSave,
  output wire irq
);
  // one-hot power states
  localparam [2:0] ST_ACTIVE = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_WAKING = 3'b100;

  // software registers
  // full bytes are kept, except in the 4-bit mask, so software reads back what it wrote
  reg [7:0] intEnable; // sleep enable lives here
  reg [7:0] modemCtrl; // loopback and infrared enables
  reg [7:0] featureCtrl; // infrared input polarity
  reg [7:0] divisor; // sleep needs it non-zero
  reg [3:0] evtStatus; // sticky events, write one to clear
  reg [3:0] evtMask; // one passes the event to irq
  reg [3:0] modemDelta; // modem change flags, read clears
  reg [3:0] modemPrev; // last modem level, edge detect
  reg rxPrevA; // last channel a line level
  reg rxPrevB; // last decoded channel b level
  reg wakeFlag; // pending wake interrupt
  reg [2:0] pwrState; // power state
  reg [11:0] oscCnt; // oscillator restart model
  reg [32:0] idleCnt; // pump idle timer
  reg [15:0] recovCnt; // pump recovery timer
  reg pumpReady; // pump has recovered
  reg psPrev; // power-save one cycle ago
  reg pumpPrev; // pump state one cycle ago
  // infrared encoder
  reg [3:0] subTick; // 16x sub-bit position
  reg [7:0] subDiv; // 16x tick divider
  reg irPulse; // encoder output
  reg irRun; // encoder is timing a pulse

  // decoded controls
  wire sleepEn = intEnable[`UPM_IER_SLEEP];
  wire loopEn = modemCtrl[`UPM_MCR_LOOP];
  wire irEn = modemCtrl[`UPM_MCR_IR];
  wire irInv = featureCtrl[`UPM_FEATURE_CONTROL_REG_INV];

  // bus isolation: the core sees no access in power-save
  // only the strobes are gated; address and data mean nothing without them
  wire busWr = regWrite & ~powerSave; // RQ6
  wire busRd = regRead & ~powerSave; // RQ6
  wire thrWrite = busWr & (regAddr == `UPM_OFS_THR);
  wire isrRead = busRd & (regAddr == `UPM_OFS_ISR);
  wire msrRead = busRd & (regAddr == `UPM_OFS_MSR);
  wire evtWrite = busWr & (regAddr == `UPM_OFS_EVT);

  // channel b line: infrared decode and polarity
  // a sensed light pulse comes out as a high bit
  wire irIn = irInv ? ~chanBSerialIn : chanBSerialIn; // RQ15
  wire lineB = irEn ? irIn : chanBSerialIn; // RQ16
  // loopback routes each transmit shifter to its receiver
  assign rxToCoreA = loopEn ? txSerialA : rxLineA; // RQ17
  assign rxToCoreB = loopEn ? txSerialB : lineB; // RQ17

  // channel b output idles low in infrared mode
  // channel a never gets an encoder
  assign chanBSerialOut = irEn ? irPulse : txSerialB; // RQ14 RQ16

  // line edges; infrared idles low so its start is a rise
  wire rxRiseA = rxLineA & ~rxPrevA;
  wire rxRiseB = lineB & ~rxPrevB;
  wire rxFallA = ~rxLineA & rxPrevA;
  wire rxFallB = ~lineB & rxPrevB;
  wire rxStart = rxFallA | (irEn ? rxRiseB : rxFallB);
  // receive idle level differs for infrared
  wire rxIdle = rxLineA & (irEn ? ~lineB : lineB);
  wire [3:0] modemChg = modemIn ^ modemPrev;
  wire [3:0] modemRise = modemIn & ~modemPrev;

  // conditions for entering sleep
  // a pending wake flag holds the core awake until the source is read
  wire sleepOk = ~coreIntPending & ~wakeFlag & sleepEn // RQ18 RQ8
    & (divisor != `UPM_RST_DIV) // RQ18
    & (modemDelta == `UPM_ZERO4) & (modemChg == `UPM_ZERO4) // RQ18
    & rxIdle; // RQ18
  // in power-save the bus cannot wake the core
  wire wakeSrc = rxStart | (|modemChg) | thrWrite; // RQ7
  // pump restart uses the rise of the line and modem inputs
  wire pumpWake = rxRiseA | rxRiseB | thrWrite | (|modemRise); // RQ3

  assign sleeping = pwrState[1];
  assign powerSave = sleeping & busIsolationPin; // RQ6
  // drivers are tri-stated whenever the pump is down
  assign rs485DrvEn = pumpOn ? drvRequest : 2'b00; // RQ2
  assign irq = |(evtStatus & evtMask);

  // edge history of the line and modem inputs
  // reset values match the idle levels, so no false edge follows reset
  always @(posedge core_clk) begin
    if (!rst_n) begin
      modemPrev <= `UPM_ZERO4;
      rxPrevA <= 1'b1;
      rxPrevB <= 1'b1;
      psPrev <= 1'b0;
      pumpPrev <= 1'b1;
    end else begin
      modemPrev <= modemIn;
      rxPrevA <= rxLineA;
      rxPrevB <= lineB;
      psPrev <= powerSave;
      pumpPrev <= pumpOn;
    end
  end

  // software registers; isolated while in power-save
  always @(posedge core_clk) begin
    if (!rst_n) begin
      intEnable <= `UPM_RST_BYTE;
      modemCtrl <= `UPM_RST_BYTE;
      featureCtrl <= `UPM_RST_BYTE;
      divisor <= `UPM_RST_DIV;
      evtMask <= `UPM_ZERO4;
      txLoad <= 1'b0;
      txLoadData <= `UPM_RST_BYTE;
    end else begin
      txLoad <= thrWrite;
      if (thrWrite) begin
        txLoadData <= regWrData;
      end
      if (busWr) begin
        case (regAddr)
          `UPM_OFS_IER: intEnable <= regWrData; // RQ9
          `UPM_OFS_MCR: modemCtrl <= regWrData; // RQ14 RQ17
          `UPM_OFS_FEATURE_CONTROL_REG: featureCtrl <= regWrData; // RQ15
          `UPM_OFS_DIV: divisor <= regWrData;
          `UPM_OFS_MASK: evtMask <= regWrData[3:0];
          default: begin
          end
        endcase
      end
    end
  end

  // modem delta flags: a change wins over the clearing read
  always @(posedge core_clk) begin
    if (!rst_n) begin
      modemDelta <= `UPM_ZERO4;
    end else begin
      modemDelta <= (msrRead ? `UPM_ZERO4 : modemDelta) | modemChg; // RQ8
    end
  end

  // register read, data one cycle after the strobe
  // unused and write-only offsets read as zero
  always @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData <= `UPM_RST_BYTE;
    end else if (busRd) begin
      case (regAddr)
        `UPM_OFS_IER: regRdData <= intEnable;
        // wake and no-pending share one code
        `UPM_OFS_ISR: regRdData <= coreIntPending ? // RQ11
          {`UPM_ZERO4, coreIntCode} : `UPM_ISR_NONE; // RQ10
        `UPM_OFS_MCR: regRdData <= modemCtrl;
        `UPM_OFS_MSR: regRdData <= {modemIn, modemDelta};
        `UPM_OFS_FEATURE_CONTROL_REG: regRdData <= featureCtrl;
        `UPM_OFS_DIV: regRdData <= divisor;
        `UPM_OFS_EVT: regRdData <= {`UPM_ZERO4, evtStatus};
        `UPM_OFS_MASK: regRdData <= {`UPM_ZERO4, evtMask};
        `UPM_OFS_STAT: regRdData <= {2'b00, wakeFlag, pumpReady,
          pumpOn, pwrState}; // RQ4
        default: regRdData <= `UPM_RST_BYTE;
      endcase
    end else begin
      // one-cycle answer only
      regRdData <= `UPM_RST_BYTE;
    end
  end

  // power state: sleep, then oscillator restart on wake
  // the restart delay is a fixed count of core clocks, a stand-in for
  // a crystal that needs time to settle
  // characters arriving while waking may be lost by the core
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pwrState <= ST_ACTIVE;
      oscCnt <= 12'h000;
    end else begin
      case (pwrState)
        ST_ACTIVE: begin
          // re-entered automatically while enabled
          if (sleepOk) begin // RQ18 RQ9
            pwrState <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wakeSrc) begin // RQ7
            pwrState <= ST_WAKING;
            oscCnt <= 12'h000;
          end
        end
        ST_WAKING: begin
          // data may drop until the oscillator is stable
          if (oscCnt == `UPM_OSC_CYC) begin // RQ12
            pwrState <= ST_ACTIVE;
          end else begin
            oscCnt <= oscCnt + 12'h001;
          end
        end
        default: pwrState <= ST_ACTIVE;
      endcase
    end
  end

  // wake interrupt: raised once the oscillator runs
  wire wakeDone = pwrState[2] & (oscCnt == `UPM_OSC_CYC) & sleepEn;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wakeFlag <= 1'b0;
    end else if (wakeDone) begin
      wakeFlag <= 1'b1; // RQ10
    end else if (isrRead) begin
      wakeFlag <= 1'b0; // RQ10
    end
  end

  // charge pump and its idle timer
  // a wake event outranks sleep: a line rise while asleep turns the pump
  // on for one cycle only, since the core stays asleep; an infrared start rise on channel b wakes the core and the pump stays on
  // the 33-bit timer is needed: 30 s is past 2^32 cycles
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pumpOn <= 1'b1;
      idleCnt <= 33'h0;
    end else if (!autoPumpShutdownSelect) begin
      pumpOn <= 1'b1; // RQ19
      idleCnt <= 33'h0;
    end else if (pumpWake) begin
      pumpOn <= 1'b1; // RQ3
      idleCnt <= 33'h0;
    end else if (sleeping) begin
      pumpOn <= 1'b0; // RQ5
      idleCnt <= 33'h0;
    end else if (txActive | (|modemChg)) begin
      idleCnt <= 33'h0; // RQ19
    end else if (idleCnt >= PUMP_IDLE_CYC[32:0] - 33'h1) begin
      pumpOn <= 1'b0; // RQ1
    end else begin
      idleCnt <= idleCnt + 33'h1; // RQ19
    end
  end

  // recovery timer; software polls it before sending
  // nothing here blocks a send; waiting is left to the host
  always @(posedge core_clk) begin
    if (!rst_n) begin
      recovCnt <= 16'h0000;
      pumpReady <= 1'b1;
    end else if (!pumpOn) begin
      recovCnt <= 16'h0000;
      pumpReady <= 1'b0;
    end else if (!pumpReady) begin
      if (recovCnt >= PUMP_RECOV_CYC - 16'h0001) begin
        pumpReady <= 1'b1; // RQ4
      end else begin
        recovCnt <= recovCnt + 16'h0001;
      end
    end
  end

  // sticky events; a set in the clearing cycle survives
  // events are edges of the pump and power-save levels or the one-cycle wakeDone, so each counts once
  wire [3:0] evtSet = {powerSave & ~psPrev, wakeDone,
    pumpOn & ~pumpPrev, ~pumpOn & pumpPrev};
  always @(posedge core_clk) begin
    if (!rst_n) begin
      evtStatus <= `UPM_ZERO4;
    end else begin
      evtStatus <= (evtWrite ? evtStatus & ~regWrData[3:0] : evtStatus)
        | evtSet;
    end
  end

  // 16x sub-bit tick from the divisor
  // a zero divisor gives a tick on every clock, the shortest pulse
  wire subTickEn = (subDiv == `UPM_RST_DIV);
  always @(posedge core_clk) begin
    if (!rst_n || txBitStartB) begin
      subDiv <= divisor;
    end else if (subTickEn) begin
      subDiv <= divisor;
    end else begin
      subDiv <= subDiv - 8'h01;
    end
  end

  // infrared encoder: high for 3 of 16 ticks on a zero bit
  // one bits leave the output low; a new bit start restarts the count, so a one bit cuts any pulse short
  always @(posedge core_clk) begin
    if (!rst_n) begin
      subTick <= 4'h0;
      irPulse <= 1'b0;
      irRun <= 1'b0;
    end else if (!irEn) begin
      subTick <= 4'h0;
      irPulse <= 1'b0; // RQ14
      irRun <= 1'b0;
    end else if (txBitStartB) begin
      subTick <= 4'h0;
      irPulse <= ~txSerialB; // RQ13
      irRun <= ~txSerialB;
    end else if (irRun && subTickEn) begin
      if (subTick == `UPM_IR_ON_TICKS - 4'h1) begin
        irPulse <= 1'b0; // RQ13
        irRun <= 1'b0;
      end
      subTick <= subTick + 4'h1;
    end
  end
endmodule

// ==== sim/upm_line_partner.sv ====
// line side model: rs-485 receiver pair and a light module on channel b
// assumes the bench steers line level and light; core_clk is the block clock
module upm_line_partner (
  // clock
  input wire logic core_clk,
  // block side
  input wire logic chanBSerialOut,
  output logic rxLineA,
  output logic chanBSerialIn,
  // bench side
  input wire logic lineA,
  input wire logic light,
  input wire logic lowActive,
  output logic [7:0] pulseWidth
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] run = 8'h00; // cycles of the pulse in progress
  // receivers stay live whatever the pump does, so the line passes straight
  assign rxLineA = lineA;
  // some modules report light as a low level
  assign chanBSerialIn = lowActive ? ~light : light;
  initial pulseWidth = 8'h00;
  // width of the last light pulse sent, in clock cycles
  always @(posedge core_clk) begin
    if (chanBSerialOut) begin
      run <= run + 8'h01;
    end else begin
      if (run != 8'h00) begin
        pulseWidth <= run;
      end
      run <= 8'h00;
    end
  end
endmodule

// ==== sim/upm_power_line_monitor.sv ====
// port checker for the power and line mode block
// assumes one clock domain; mode bits are tracked from register writes
`include "upm_defs.vh"
module upm_power_line_monitor (
  input wire logic core_clk, rst_n, regWrite, regRead, autoPumpShutdownSelect,
  input wire logic busIsolationPin, txSerialA, txSerialB, txBitStartB, rxToCoreA,
  input wire logic txLoad, chanBSerialOut, pumpOn, sleeping, powerSave,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData, regRdData, txLoadData,
  input wire logic [1:0] drvRequest, rs485DrvEn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic loopOn; // shadow of the loopback bit
  logic irOn; // shadow of the infrared bit
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // writes are refused in power-save, so the shadow skips them too
  always @(posedge core_clk) begin
    if (!rst_n) begin
      loopOn <= 1'b0;
      irOn <= 1'b0;
    end else if (regWrite && !powerSave && regAddr == `UPM_OFS_MCR) begin
      loopOn <= regWrData[`UPM_MCR_LOOP];
      irOn <= regWrData[`UPM_MCR_IR];
    end
  end
  AST_DRV_OFF: assert property (!pumpOn |-> rs485DrvEn == 2'b00)
    else $error("drivers enabled with pump off");
  AST_DRV_ON: assert property (pumpOn |-> rs485DrvEn == drvRequest)
    else $error("drivers differ from request");
  AST_PSAVE: assert property (powerSave == (sleeping && busIsolationPin))
    else $error("power-save state wrong");
  AST_PS_READ: assert property (powerSave && regRead |=> regRdData == 8'h00)
    else $error("read answered in power-save");
  AST_PUMP_SEL: assert property (!autoPumpShutdownSelect |=> pumpOn)
    else $error("pump off while select low");
  AST_SLEEP_OFF: assert property ($rose(sleeping) && autoPumpShutdownSelect |=> !pumpOn)
    else $error("pump kept on in sleep");
  AST_TX_LOAD: assert property (regWrite && !powerSave && regAddr == `UPM_OFS_THR
    |=> txLoad && txLoadData == $past(regWrData)) else $error("holding write lost");
  AST_LOOP: assert property (loopOn |-> rxToCoreA == txSerialA)
    else $error("loopback path broken");
  AST_IR_IDLE: assert property (!irOn |-> chanBSerialOut == txSerialB)
    else $error("channel b output altered");
  AST_IR_PULSE: assert property (irOn && txBitStartB && !txSerialB |=> chanBSerialOut[*3])
    else $error("zero bit pulse too short");
  cover property ($rose(powerSave));
  cover property ($fell(pumpOn));
  cover property (irOn && txBitStartB && !txSerialB);
endmodule
bind upm_power_line upm_power_line_monitor u_mon (.core_clk, .rst_n, .regWrite, .regRead,
  .autoPumpShutdownSelect, .busIsolationPin, .txSerialA, .txSerialB, .txBitStartB,
  .rxToCoreA, .txLoad, .chanBSerialOut, .pumpOn, .sleeping, .powerSave, .regAddr,
  .regWrData, .regRdData, .txLoadData, .drvRequest, .rs485DrvEn);

// ==== sim/tb.sv ====
// self-checking bench for the power and line mode block
// assumes one 200 MHz clock; short idle and recovery counts are set here
`include "upm_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic autoPumpShutdownSelect = 1'b0, busIsolationPin = 1'b0, txActive = 1'b0;
  logic coreIntPending = 1'b0, txSerialA = 1'b1, txSerialB = 1'b1, txBitStartB = 1'b0;
  logic lineA = 1'b1, light = 1'b1, lowActive = 1'b0;
  logic [3:0] regAddr = 4'h0, modemIn = 4'h0, coreIntCode = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData, txLoadData, pulseWidth;
  logic [1:0] drvRequest = 2'h0, rs485DrvEn;
  logic rxToCoreA, rxToCoreB, txLoad, rxLineA, chanBSerialIn, chanBSerialOut;
  logic pumpOn, sleeping, powerSave, irq;
  int fail_count = 0, total_checks = 0, n;
  upm_power_line #(.PUMP_IDLE_CYC(64'd50), .PUMP_RECOV_CYC(16'd20)) uut (.core_clk,
    .rst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .autoPumpShutdownSelect, .busIsolationPin, .modemIn, .txActive, .coreIntPending,
    .coreIntCode, .txSerialA, .txSerialB, .txBitStartB, .drvRequest, .rxToCoreA,
    .rxToCoreB, .txLoad, .txLoadData, .rxLineA, .chanBSerialIn, .chanBSerialOut,
    .rs485DrvEn, .pumpOn, .sleeping, .powerSave, .irq);
  upm_line_partner u_part (.core_clk, .chanBSerialOut, .rxLineA, .chanBSerialIn,
    .lineA, .light, .lowActive, .pulseWidth);
  always #2.5 core_clk = ~core_clk;
  // wait k edges, then look just after the last one so its updates landed
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk8(nm, e, regRdData);
  endtask
  // bounded wait for the sleep flag to reach a level
  task automatic waitsl(input logic want, input int lim);
    n = 0;
    while (sleeping !== want && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // the whole sequence needs about 1100 cycles
  initial begin
    #(6000 * 5);
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(1);
    chk1("pump at reset", 1'b1, pumpOn);
    rd(4'hf, 8'h00, "unmapped");
    // infrared encoder, decoder and channel a untouched
    wr(`UPM_OFS_MCR, 8'h40);
    cyc(2);
    chk1("txb idle", 1'b0, chanBSerialOut);
    for (int b = 0; b < 2; b++) begin
      @(posedge core_clk);
      txSerialB <= b[0];
      txBitStartB <= 1'b1;
      @(posedge core_clk);
      txBitStartB <= 1'b0;
      cyc(0);
      chk1("pulse level", ~b[0], chanBSerialOut);
      cyc(8);
      chk8("pulse width", 8'h03, pulseWidth);
    end
    chk1("no pulse on one", 1'b0, chanBSerialOut);
    @(posedge core_clk);
    lineA <= 1'b0;
    cyc(1);
    chk1("ir rx", 1'b1, rxToCoreB);
    chk1("chan a plain", 1'b0, rxToCoreA);
    wr(`UPM_OFS_FEATURE_CONTROL_REG, 8'h04);
    @(posedge core_clk);
    lowActive <= 1'b1;
    cyc(1);
    chk1("ir rx inverted", 1'b1, rxToCoreB);
    wr(`UPM_OFS_MCR, 8'h10);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      txSerialA <= v[0];
      lineA <= ~v[0];
      cyc(1);
      chk1("loopback", v[0], rxToCoreA);
    end
    wr(`UPM_OFS_MCR, 8'h00);
    wr(`UPM_OFS_FEATURE_CONTROL_REG, 8'h00);
    wr(`UPM_OFS_DIV, 8'h01);
    // idle shutdown of the pump and its three restart events
    @(posedge core_clk);
    lowActive <= 1'b0;
    lineA <= 1'b1;
    drvRequest <= 2'h3;
    autoPumpShutdownSelect <= 1'b1;
    cyc(30);
    @(posedge core_clk);
    txActive <= 1'b1;
    @(posedge core_clk);
    txActive <= 1'b0;
    cyc(40);
    chk1("pump held", 1'b1, pumpOn);
    cyc(20);
    chk1("pump idle off", 1'b0, pumpOn);
    chk8("drivers off", 8'h00, {6'h00, rs485DrvEn});
    rd(`UPM_OFS_EVT, 8'h01, "event pump off");
    for (int e = 0; e < 3; e++) begin
      if (e == 1) begin
        wr(`UPM_OFS_THR, 8'h5a);
        cyc(0);
        chk1("tx load", 1'b1, txLoad);
        chk8("tx data", 8'h5a, txLoadData);
      end else begin
        @(posedge core_clk);
        lineA <= (e == 2);
        modemIn <= {3'h0, e == 2};
        @(posedge core_clk);
        lineA <= 1'b1;
      end
      cyc(4);
      chk1("pump restart", 1'b1, pumpOn);
      chk8("drivers on", 8'h03, {6'h00, rs485DrvEn});
      rd(`UPM_OFS_STAT, 8'h09, "pump recovering");
      cyc(20);
      rd(`UPM_OFS_STAT, 8'h19, "pump recovered");
      cyc(60);
      chk1("pump off again", 1'b0, pumpOn);
    end
    rd(`UPM_OFS_MSR, 8'h11, "modem delta");
    rd(`UPM_OFS_MSR, 8'h10, "modem cleared");
    wr(`UPM_OFS_EVT, 8'h0f);
    // sleep entry, power-save isolation, wake and return
    @(posedge core_clk);
    coreIntPending <= 1'b1;
    coreIntCode <= 4'h5;
    wr(`UPM_OFS_IER, 8'h10);
    rd(`UPM_OFS_ISR, 8'h05, "isr pending");
    cyc(10);
    chk1("no sleep pending", 1'b0, sleeping);
    wr(`UPM_OFS_MASK, 8'h04);
    wr(`UPM_OFS_THR, 8'h33);
    @(posedge core_clk);
    coreIntPending <= 1'b0;
    waitsl(1'b1, 40);
    chk1("sleep entered", 1'b1, sleeping);
    cyc(1);
    chk1("pump off asleep", 1'b0, pumpOn);
    @(posedge core_clk);
    busIsolationPin <= 1'b1;
    cyc(2);
    chk1("power-save", 1'b1, powerSave);
    rd(`UPM_OFS_MSR, 8'h00, "isolated read");
    wr(`UPM_OFS_THR, 8'h44);
    cyc(0);
    chk1("isolated strobe", 1'b0, txLoad);
    chk8("isolated load", 8'h33, txLoadData);
    cyc(10);
    chk1("bus no wake", 1'b1, sleeping);
    @(posedge core_clk);
    modemIn <= 4'h3;
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    chk1("wake after osc", 1'b1, n >= 256);
    chk1("wake irq", 1'b1, irq);
    rd(`UPM_OFS_ISR, 8'h01, "isr wake");
    rd(`UPM_OFS_MSR, 8'h32, "wake modem");
    wr(`UPM_OFS_EVT, 8'h0f);
    waitsl(1'b1, 100);
    chk1("back asleep", 1'b1, sleeping);
    chk1("back in power-save", 1'b1, powerSave);
    @(posedge core_clk);
    busIsolationPin <= 1'b0;
    cyc(2);
    chk1("pin low", 1'b0, powerSave);
    wr(`UPM_OFS_IER, 8'h00);
    wr(`UPM_OFS_THR, 8'h55);
    cyc(300);
    chk1("stays awake", 1'b0, sleeping);
    rd(`UPM_OFS_STAT, 8'h01, "awake without wake flag");
    finish_test;
  end
endmodule
